//--- sar_adc_sense_sequencer.sv
// The register addresses and strobed register access were decided locally.
`include "sense_seq_defines.svh"
module sar_adc_sense_sequencer #(
  parameter int RESULT_WIDTH = 10,
  parameter int SEQ_CHANNELS = 11
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Register port
  input wire sense_seq_pkg::reg_req_type reg_req_i,
  output logic [15:0] reg_rdata_o,
  // Analog converter side
  output sense_seq_pkg::adc_ctl_type adc_ctl_o,
  input wire logic [RESULT_WIDTH-1:0] adc_result_i,
  // Core notification
  output logic done_irq_o
);
  import sense_seq_pkg::*;

  // Result packing and the sequence decode only serve these ranges
  if (RESULT_WIDTH != 10 || SEQ_CHANNELS < 1 || SEQ_CHANNELS > 11) begin : g_param_check
    $error("Unsupported sense sequencer parameters");
  end

  // Configuration and sequencer state
  mode_type mode;
  state_type state;
  logic cont;
  logic enable;
  logic [4:0] single_channel;
  logic [4:0] channel;
  // Programmable phase lengths and the shared down-counter
  logic [7:0] en_time;
  logic [7:0] sample_time;
  logic [7:0] count;
  // Result storage
  logic [RESULT_WIDTH-1:0] single_result;
  logic [RESULT_WIDTH-1:0] seq_result [SEQ_CHANNELS];
  // Internal strobes and status
  logic start;
  logic busy;
  logic last_seq;

  // Control writes; start is a one-cycle request
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mode <= MODE_SINGLE;
      cont <= 1'b0;
      enable <= 1'b0;
      single_channel <= 5'h00;
      en_time <= `RESET_EN_TIME;
      sample_time <= `RESET_SAMPLE_TIME;
      start <= 1'b0;
    end else begin
      start <= 1'b0;
      if (reg_req_i.wr && reg_req_i.addr == `ADDR_CTRL) begin
        // Mode 3 is reserved and falls back to single
        if (reg_req_i.wdata[`CTRL_MODE_LSB+:2] == 2'h3) begin
          mode <= MODE_SINGLE;
        end else begin
          mode <= mode_type'(reg_req_i.wdata[`CTRL_MODE_LSB+:2]);
        end
        cont <= reg_req_i.wdata[`CTRL_CONT_BIT];
        enable <= reg_req_i.wdata[`CTRL_ENABLE_BIT];
        start <= reg_req_i.wdata[`CTRL_START_BIT];
      end else if (reg_req_i.wr && reg_req_i.addr == `ADDR_SINGLE) begin
        single_channel <= reg_req_i.wdata[4:0];
      end else if (reg_req_i.wr && reg_req_i.addr == `ADDR_EN_TIME) begin
        en_time <= reg_req_i.wdata[7:0];
      end else if (reg_req_i.wr && reg_req_i.addr == `ADDR_SAMPLE_TIME) begin
        sample_time <= reg_req_i.wdata[7:0];
      end
    end
  end

  // Busy covers every phase, so a start while running is dropped
  assign busy = (state != ST_IDLE);
  // Sequence end: the smaller of the parameter and the fixed ceiling wins
  assign last_seq = (channel >= 5'(SEQ_CHANNELS - 1)) || (channel >= `SEQ_LAST_CHANNEL);

  // Conversion sequencer; the analog dividers scale only the voltage inputs in front of the mux
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      channel <= 5'h00;
      count <= 8'h00;
    end else if (!enable) begin
      state <= ST_IDLE; // Disable aborts and forces the enable time again
      count <= 8'h00;
    end else begin
      case (state)
        ST_IDLE: begin
          // Only idle looks at start, which is how a busy start is refused
          if (start) begin
            channel <= (mode == MODE_SINGLE) ? single_channel : 5'h00;
            count <= en_time;
            state <= ST_ENABLE;
          end
        end
        ST_ENABLE: begin
          // Settling time after the converter is switched on
          if (count == 8'h00) begin
            count <= sample_time;
            state <= ST_SAMPLE;
          end else begin
            count <= count - 8'h01;
          end
        end
        ST_SAMPLE: begin
          // Sample window; the mux select is already stable here
          if (count == 8'h00) begin
            count <= {3'h0, `CONVERT_CYCLES} - 8'h01;
            state <= ST_CONVERT;
          end else begin
            count <= count - 8'h01;
          end
        end
        ST_CONVERT: begin
          // Fixed conversion time; the result is taken on its last cycle
          if (count == 8'h00) begin
            count <= {6'h00, `IRQ_CYCLES} - 8'h01;
            state <= (mode == MODE_SINGLE) ? ST_IRQ : ST_STORE;
          end else begin
            count <= count - 8'h01;
          end
        end
        ST_IRQ: begin
          if (count == 8'h00) begin
            count <= sample_time;
            // Repeat mode reuses the enabled converter, so no enable time
            // One-time mode ignores the repeat bit and stops after one lap; round robin never reaches here
            state <= (cont && mode == MODE_SINGLE) ? ST_SAMPLE : ST_IDLE;
          end else begin
            count <= count - 8'h01;
          end
        end
        ST_STORE: begin
          // One cycle between channels while the mux moves on
          count <= sample_time;
          if (!last_seq) begin
            channel <= channel + 5'h01;
            state <= ST_SAMPLE;
          end else if (mode == MODE_ROUND_ROBIN) begin
            channel <= 5'h00;
            state <= ST_SAMPLE;
          end else begin
            count <= {6'h00, `IRQ_CYCLES} - 8'h01;
            state <= ST_IRQ;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Single result held until the next single conversion
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      single_result <= '0;
    end else if (state == ST_CONVERT && count == 8'h00 && mode == MODE_SINGLE) begin
      single_result <= adc_result_i;
    end
  end

  // One register per sequenced channel
  // Only the channel being converted is written; the others hold
  for (genvar i = 0; i < SEQ_CHANNELS; i++) begin : g_result
    always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
        seq_result[i] <= '0;
      end else if (state == ST_CONVERT && count == 8'h00 && mode != MODE_SINGLE &&
                   channel == 5'(i)) begin
        seq_result[i] <= adc_result_i;
      end
    end
  end

  // Read data, one cycle after the strobe; unmapped reads return zero
  // Reads have no side effects, so firmware may poll at any time
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_req_i.rd) begin
      if (reg_req_i.addr == `ADDR_CTRL) begin
        reg_rdata_o <= {12'h000, enable, cont, mode};
      end else if (reg_req_i.addr == `ADDR_STATUS) begin
        reg_rdata_o <= {10'h000, busy, channel};
      end else if (reg_req_i.addr == `ADDR_SINGLE) begin
        reg_rdata_o <= {1'b0, single_channel, single_result};
      end else if (reg_req_i.addr == `ADDR_EN_TIME) begin
        reg_rdata_o <= {8'h00, en_time};
      end else if (reg_req_i.addr == `ADDR_SAMPLE_TIME) begin
        reg_rdata_o <= {8'h00, sample_time};
      end else if (reg_req_i.addr >= `ADDR_RESULT_BASE &&
                   5'(reg_req_i.addr) < 5'(`ADDR_RESULT_BASE) + 5'(SEQ_CHANNELS)) begin
        reg_rdata_o <= {6'h00, seq_result[reg_req_i.addr - `ADDR_RESULT_BASE]};
      end else begin
        reg_rdata_o <= 16'h0000;
      end
    end
  end

  // Converter controls; the channel is held from enable through conversion
  always_comb begin
    adc_ctl_o.channel = channel;
    adc_ctl_o.sample = (state == ST_SAMPLE);
    adc_ctl_o.convert = (state == ST_CONVERT);
  end

  // Interrupt pulse after single completion or one-time sequence end
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      done_irq_o <= 1'b0;
    end else begin
      // Clearing enable cuts the pulse short along with the sequence
      done_irq_o <= (state == ST_IRQ) && enable;
    end
  end
endmodule : sar_adc_sense_sequencer

//--- sense_seq_defines.svh
`ifndef SENSE_SEQ_DEFINES_SVH
`define SENSE_SEQ_DEFINES_SVH
// Functional notes
// - Results are 10-bit converter values
// - Automatic sequence covers at most 11 channels
// - Firmware may request one single-channel conversion
// - Sequence uses channels 0..10 only
// - Voltage channels divided, current channels undivided
// - Completed results held for firmware reads
// - Conversion takes 12 clocks after sampling
// - Single completion pulses interrupt two clocks
// - Round robin overwrites earlier channel result
// - One-time sequence stops, then interrupts
`define ADDR_CTRL 4'h0
`define ADDR_STATUS 4'h1
`define ADDR_SINGLE 4'h2
`define ADDR_EN_TIME 4'h3
`define ADDR_SAMPLE_TIME 4'h4
`define ADDR_RESULT_BASE 4'h5
`define CTRL_MODE_LSB 0
`define CTRL_CONT_BIT 2
`define CTRL_ENABLE_BIT 3
`define CTRL_START_BIT 4
`define RESET_EN_TIME 8'h04
`define RESET_SAMPLE_TIME 8'h04
`define CONVERT_CYCLES 5'd12
`define IRQ_CYCLES 2'd2
`define SEQ_LAST_CHANNEL 5'd10
`define DIV5_CHANNEL_PIN1 5'd8
`define DIV5_CHANNEL_PIN2 5'd10
`define DIV2_CHANNEL_PIN1 5'd12
`define DIV2_CHANNEL_PIN2 5'd13
`endif

//--- sense_seq_pkg.sv
package sense_seq_pkg;
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_ROUND_ROBIN = 2'h1,
    MODE_ONE_TIME = 2'h2
  } mode_type;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ENABLE = 6'h02,
    ST_SAMPLE = 6'h04,
    ST_CONVERT = 6'h08,
    ST_IRQ = 6'h10,
    ST_STORE = 6'h20
  } state_type;
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;
  typedef struct packed {
    logic [4:0] channel;
    logic sample;
    logic convert;
  } adc_ctl_type;
endpackage : sense_seq_pkg

//--- sense_seq_asserts.sv
module sense_seq_asserts #(
  parameter int RESULT_WIDTH = 10,
  parameter int SEQ_CHANNELS = 11
) (
  // Watched ports
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire sense_seq_pkg::reg_req_type reg_req_i,
  input wire logic [15:0] reg_rdata_o,
  input wire sense_seq_pkg::adc_ctl_type adc_ctl_o,
  input wire logic [RESULT_WIDTH-1:0] adc_result_i,
  input wire logic done_irq_o
);
  import sense_seq_pkg::*;
  logic cv;
  logic sm;
  // Short aliases for the converter strobes
  assign cv = adc_ctl_o.convert;
  assign sm = adc_ctl_o.sample;
  // One clock domain, so clock and reset are given once
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  conv_len_a: assert property ($rose(cv) |-> cv [*8] ##1 cv [*4] ##1 !cv)
    else $error("conversion not 12 cycles");
  samp_conv_a: assert property ($rose(cv) |-> $past(sm))
    else $error("conversion without sampling");
  samp_end_a: assert property ($fell(sm) |-> cv)
    else $error("sampling not followed by conversion");
  excl_phase_a: assert property (!(sm && cv))
    else $error("sample and convert together");
  chan_hold_a: assert property (cv |-> $stable(adc_ctl_o.channel))
    else $error("channel moved in conversion");
  irq_len_a: assert property ($rose(done_irq_o) |->
    done_irq_o ##1 done_irq_o ##1 !done_irq_o)
    else $error("interrupt not two cycles");
  irq_cause_a: assert property ($rose(done_irq_o) |->
    $past(cv, 2) || $past(cv, 3))
    else $error("interrupt without conversion");
  res_width_a: assert property (reg_req_i.rd && reg_req_i.addr >= 4'h5 |=>
    reg_rdata_o[15:10] == 6'h00)
    else $error("result wider than 10 bits");
endmodule : sense_seq_asserts

//--- adc_model.sv
module adc_model (
  // Clock
  input wire logic ref_clk_i,
  // Converter control and result
  input wire sense_seq_pkg::adc_ctl_type ctl_i,
  input wire logic [4:0] salt_i,
  output logic [9:0] result_o = 10'h155
);
  import sense_seq_pkg::*;
  // Result valid only in conversion; it toggles otherwise so a stale capture shows
  always_ff @(posedge ref_clk_i) begin
    result_o <= ctl_i.convert ? {ctl_i.channel, salt_i} : ~result_o;
  end
endmodule : adc_model

//--- testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import sense_seq_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  reg_req_type req = '0;
  logic [15:0] rdata;
  adc_ctl_type ctl;
  logic [9:0] res;
  logic irq;
  logic [4:0] salt = 5'h00;
  logic rd_seen = 1'b0;
  logic seq_on = 1'b0;
  logic [7:0] en_t;
  logic [15:0] exp_q[$];
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  int seed = 32'h4a7f;
  sar_adc_sense_sequencer sar_adc_sense_sequencer_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .reg_req_i(req), .reg_rdata_o(rdata), .adc_ctl_o(ctl), .adc_result_i(res),
    .done_irq_o(irq));
  adc_model adc_model_i (.ref_clk_i(ref_clk_i), .ctl_i(ctl), .salt_i(salt), .result_o(res));
  // Clock
  initial begin
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic end_sim;
    if (failures == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim
  // One bus cycle per call, so no strobe is driven twice in a step
  task automatic bus(input logic [3:0] a, input logic [15:0] d, input logic w, input logic r);
    @(posedge ref_clk_i);
    req <= '{a, d, w, r};
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    bus(a, 16'h0000, 1'b0, 1'b1);
  endtask : rd
  task automatic wait_irq(input int lim);
    bus(4'h0, 16'h0000, 1'b0, 1'b0);
    while (irq !== 1'b1 && lim > 0) begin
      @(posedge ref_clk_i);
      lim--;
    end
    if (lim == 0) failures++;
  endtask : wait_irq
  // Read tracking and hang guard
  always @(posedge ref_clk_i) begin
    rd_seen <= req.rd;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end
  // Read data is checked in the cycle after the strobe; it holds until the next read
  always @(negedge ref_clk_i) begin
    if (rd_seen) check(rdata, exp_q.pop_front());
    if (seq_on && ctl.sample) check(16'(ctl.channel > 5'd10), 16'h0000);
  end
  initial begin
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd(4'h3, 16'h0004);
    rd(4'h4, 16'h0004);
    en_t = 8'($random(seed)) & 8'h03;
    bus(4'h3, {8'h00, en_t}, 1'b1, 1'b0);
    bus(4'h4, {8'h00, en_t ^ 8'h01}, 1'b1, 1'b0);
    rd(4'h4, {8'h00, en_t ^ 8'h01});
    for (int ch = 0; ch < 32; ch++) begin
      salt <= 5'($random(seed));
      bus(4'h2, {11'h000, 5'(ch)}, 1'b1, 1'b0);
      bus(4'h0, 16'h0018, 1'b1, 1'b0);
      wait_irq(300);
      rd(4'h2, {1'b0, 5'(ch), 5'(ch), salt});
    end
    // Continuous single: a second pulse comes with no new start
    bus(4'h0, 16'h001C, 1'b1, 1'b0);
    wait_irq(300);
    repeat (3) @(posedge ref_clk_i);
    // Clearing the repeat bit lets the running conversion finish, then stop
    bus(4'h0, 16'h0008, 1'b1, 1'b0);
    wait_irq(300);
    repeat (3) @(posedge ref_clk_i);
    rd(4'h2, {1'b0, 5'd31, 5'd31, salt});
    seq_on = 1'b1;
    salt <= 5'($random(seed));
    bus(4'h0, 16'h001A, 1'b1, 1'b0);
    wait_irq(2000);
    for (int ch = 0; ch < 11; ch++) rd(4'(ch + 5), {6'h00, 5'(ch), salt});
    bus(4'h0, 16'h0000, 1'b0, 1'b0);
    repeat (40) @(posedge ref_clk_i);
    check(16'(ctl.convert), 16'h0000);
    salt <= ~salt;
    bus(4'h0, 16'h0019, 1'b1, 1'b0);
    bus(4'h0, 16'h0000, 1'b0, 1'b0);
    // First lap ends after channel 10 converts
    for (int i = 0; i < 2000 && !(ctl.convert === 1'b1 && ctl.channel === 5'd10); i++)
      @(posedge ref_clk_i);
    for (int i = 0; i < 40 && ctl.convert === 1'b1; i++) @(posedge ref_clk_i);
    repeat (2) @(posedge ref_clk_i);
    for (int ch = 0; ch < 11; ch++) rd(4'(ch + 5), {6'h00, 5'(ch), salt});
    bus(4'h0, 16'h0000, 1'b0, 1'b0);
    // Disable lands in the store cycle, so no sample or convert is cut short
    while (ctl.convert === 1'b1) @(posedge ref_clk_i);
    while (ctl.convert !== 1'b1) @(posedge ref_clk_i);
    repeat (9) @(posedge ref_clk_i);
    bus(4'h0, 16'h0000, 1'b1, 1'b0);
    bus(4'h0, 16'h0000, 1'b0, 1'b0);
    end_sim();
  end
endmodule : testbench
bind sar_adc_sense_sequencer sense_seq_asserts #(.RESULT_WIDTH(RESULT_WIDTH),
  .SEQ_CHANNELS(SEQ_CHANNELS)) sense_seq_asserts_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
  .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o), .adc_ctl_o(adc_ctl_o),
  .adc_result_i(adc_result_i), .done_irq_o(done_irq_o));
